// ===== logic/csf_buf.sv
`timescale 1ns/100ps
`default_nettype none

module csf_buf #(
   parameter int WIDTH = 97,
   parameter int DEPTH = 2
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);

   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [CW-1:0] cnt_q;
   logic push;
   logic pop;

   assign in_ready = (cnt_q != CW'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   assign out_data = mem_q[rd_q];

   function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
      nxt = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
   endfunction

   always_ff @(posedge mclk) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= nxt(wr_q);
         end
         if (pop) begin
            rd_q <= nxt(rd_q);
         end
         if (push && !pop) begin
            cnt_q <= CW'(cnt_q + 1'b1);
         end else if (pop && !push) begin
            cnt_q <= CW'(cnt_q - 1'b1);
         end
      end
   end

endmodule // csf_buf

`default_nettype wire

// ===== logic/csf_defs.svh
`ifndef CSF_DEFS_SVH
`define CSF_DEFS_SVH

// ------------------------------------------------------------
// Clock and timing
// ------------------------------------------------------------
`define CSF_CLK_HZ 100000000
`define CSF_TICK_MS 1
`define CSF_SWS_RATE_MS 250
`define CSF_GC_RATE_MS 100

// ------------------------------------------------------------
// Identifier fields
// ------------------------------------------------------------
`define CSF_PRIORITY 3'h3
`define CSF_EDP 1'h0
`define CSF_DP 1'h0
`define CSF_PF 8'hFD
`define CSF_SWS_PS 8'h91
`define CSF_GC_PS 8'h93
`define CSF_DLC 4'h8
`define CSF_FILL_BYTE 8'hFF

// ------------------------------------------------------------
// Register offsets (byte addresses)
// ------------------------------------------------------------
`define CSF_OFS_CTRL 8'h00
`define CSF_OFS_SWS 8'h04
`define CSF_OFS_GC 8'h08
`define CSF_OFS_STAT 8'h0C

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define CSF_CTRL_EN 0
`define CSF_CTRL_ENG 1
`define CSF_CTRL_SA_LO 8
`define CSF_SWS_GEN_LO 0
`define CSF_SWS_UTIL_LO 3
`define CSF_GC_NR_LO 0

// ------------------------------------------------------------
// Codes and reset values
// ------------------------------------------------------------
`define CSF_BRK_ERR 3'h6
`define CSF_BRK_NA 3'h7
`define CSF_BRK_RSV_LO 3'h3
`define CSF_BRK_RSV_HI 3'h5
`define CSF_NR_NA 2'h3
`define CSF_SA_RST 8'hFE

`endif

// ===== logic/csf_framer.sv
// How it works
// - Frames go out only while broadcast enable and engine selection bits are both set; frames already buffered when gated still drain here.
// - Identifier priority is fixed at 3; no register can change it.
// - Unimplemented parameter fields within a frame are sent as all ones.
// - Multi-byte values go first byte most significant; byte 1 is sent first.
// - Group number is PDU format high byte, PDU specific low byte, hex.
// - Switching-status frame: group 64913, FD/91, eight bytes, every 250 ms.
// - Byte 1 bits 1-3 carry generator breaker state code.
// - Byte 1 bits 4-6 carry utility breaker state, same codes.
// - Generator-control frame: group 64915, FD/93, eight bytes, every 100 ms.
// - Generator-control byte 1 bits 4-5 carry not-ready-for-auto-start state.
//
// The implementer's own choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none
`include "csf_defs.svh"

module csf_framer #(
   parameter int TICK_CYC = (`CSF_CLK_HZ / 1000) * `CSF_TICK_MS,
   parameter int SWS_TICKS = `CSF_SWS_RATE_MS / `CSF_TICK_MS,
   parameter int GC_TICKS = `CSF_GC_RATE_MS / `CSF_TICK_MS
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Frame stream to the CAN controller
   output logic frm_valid,
   input wire logic frm_ready,
   output csf_pkg::csf_frame_t frm_data
);

   import csf_pkg::*;

   localparam int TW = $clog2(TICK_CYC + 1);
   localparam int PW = 16;

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   logic ack_q;
   logic [31:0] rdat_q;
   logic bus_req;
   logic wr_commit;
   logic [7:0] word_adr;
   logic en_q;
   logic eng_q;
   logic [7:0] sa_q;
   logic [2:0] gen_q;
   logic [2:0] util_q;
   logic [1:0] nr_q;
   logic active;
   logic [TW-1:0] tick_cnt_q;
   logic tick;
   logic [PW-1:0] sws_cnt_q;
   logic [PW-1:0] gc_cnt_q;
   logic sws_fire;
   logic gc_fire;
   logic sws_pend_q;
   logic gc_pend_q;
   logic [7:0] sws_sent_q;
   logic [7:0] gc_sent_q;
   logic [7:0] ovr_q;
   logic ovr_clr;
   csf_sel_t sel;
   csf_frame_t frame;
   logic ld_valid;
   logic ld_ready;
   logic taken;
   logic sws_taken;
   logic gc_taken;
   logic sws_ovr;
   logic gc_ovr;
   logic [7:0] sws_byte1;
   logic [7:0] gc_byte1;
   logic [31:0] stat_word;
   logic [31:0] ctrl_word;
   logic [31:0] ctrl_wr;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // Reserved breaker codes are not passed on; they are reported as error
   function automatic logic [2:0] brk_code(input logic [2:0] c);
      if (c >= `CSF_BRK_RSV_LO && c <= `CSF_BRK_RSV_HI) begin
         brk_code = `CSF_BRK_ERR;
      end else begin
         brk_code = c;
      end
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      merge = r;
   endfunction

   // Identifier: priority, data pages, group number, source address
   function automatic logic [28:0] can_ident(input logic [7:0] ps, input logic [7:0] sa);
      can_ident = {`CSF_PRIORITY, `CSF_EDP, `CSF_DP, `CSF_PF, ps, sa};
   endfunction

   // ------------------------------------------------------------
   // Wishbone slave
   // ------------------------------------------------------------
   assign bus_req = wb_cyc_i & wb_stb_i;
   assign word_adr = {wb_adr_i[7:2], 2'b00};
   // Writes land on the edge at which the master samples ack
   assign wr_commit = bus_req & wb_we_i & ack_q;
   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;

   // Status is taken at the request edge, one cycle before ack
   assign stat_word = {ovr_q, gc_sent_q, sws_sent_q, 5'h00, frm_valid, gc_pend_q, sws_pend_q};

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ack_q <= 1'b0;
      end else begin
         // Ack drops for a cycle after each answer: one pulse per request
         ack_q <= bus_req & ~ack_q;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rdat_q <= 32'h0000_0000;
      end else if (bus_req && !ack_q) begin
         // Captured with the request so the data stand while ack is high
         unique case (word_adr)
            `CSF_OFS_CTRL: begin
               rdat_q <= {16'h0000, sa_q, 6'h00, eng_q, en_q};
            end
            `CSF_OFS_SWS: begin
               rdat_q <= {26'h000_0000, util_q, gen_q};
            end
            `CSF_OFS_GC: begin
               rdat_q <= {30'h0000_0000, nr_q};
            end
            `CSF_OFS_STAT: begin
               rdat_q <= stat_word;
            end
            default: begin
               // Unmapped reads give zero
               rdat_q <= 32'h0000_0000;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Control and value registers
   // ------------------------------------------------------------
   // Control word as read back; byte enables merge into it
   assign ctrl_word = {16'h0000, sa_q, 6'h00, eng_q, en_q};
   assign ctrl_wr = merge(ctrl_word, wb_dat_i, wb_sel_i);

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         en_q <= 1'b0;
         eng_q <= 1'b0;
         sa_q <= `CSF_SA_RST;
      end else if (wr_commit && word_adr == `CSF_OFS_CTRL) begin
         en_q <= ctrl_wr[`CSF_CTRL_EN];
         eng_q <= ctrl_wr[`CSF_CTRL_ENG];
         sa_q <= ctrl_wr[`CSF_CTRL_SA_LO +: 8];
      end
   end

   // Values start as not available until software reports them
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         gen_q <= `CSF_BRK_NA;
         util_q <= `CSF_BRK_NA;
      end else if (wr_commit && word_adr == `CSF_OFS_SWS && wb_sel_i[0]) begin
         gen_q <= wb_dat_i[`CSF_SWS_GEN_LO +: 3];
         util_q <= wb_dat_i[`CSF_SWS_UTIL_LO +: 3];
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         nr_q <= `CSF_NR_NA;
      end else if (wr_commit && word_adr == `CSF_OFS_GC && wb_sel_i[0]) begin
         nr_q <= wb_dat_i[`CSF_GC_NR_LO +: 2];
      end
   end

   assign ovr_clr = wr_commit && (word_adr == `CSF_OFS_STAT);

   // ------------------------------------------------------------
   // Broadcast gating and timers
   // ------------------------------------------------------------
   assign active = en_q & eng_q;

   // One-cycle tick every TICK_CYC clocks
   // Held at zero while gated, so the first frame comes a full period after enable
   assign tick = active && (tick_cnt_q == TW'(TICK_CYC - 1));

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         tick_cnt_q <= '0;
      end else if (!active || tick) begin
         tick_cnt_q <= '0;
      end else begin
         tick_cnt_q <= TW'(tick_cnt_q + 1'b1);
      end
   end

   // Separate counters so one rate never disturbs the other
   assign sws_fire = tick && (sws_cnt_q == PW'(SWS_TICKS - 1));
   assign gc_fire = tick && (gc_cnt_q == PW'(GC_TICKS - 1));

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sws_cnt_q <= '0;
      end else if (!active || sws_fire) begin
         sws_cnt_q <= '0;
      end else if (tick) begin
         sws_cnt_q <= PW'(sws_cnt_q + 1'b1);
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         gc_cnt_q <= '0;
      end else if (!active || gc_fire) begin
         gc_cnt_q <= '0;
      end else if (tick) begin
         gc_cnt_q <= PW'(gc_cnt_q + 1'b1);
      end
   end

   // ------------------------------------------------------------
   // Pending requests and arbitration
   // ------------------------------------------------------------
   // Faster group first; a stalled slow frame stays pending until taken, dropped only when gated off
   assign sel = gc_pend_q ? CSF_SEL_GC : CSF_SEL_SWS;
   // Loads stop at once when gated; frames already buffered still drain
   assign ld_valid = active & (sws_pend_q | gc_pend_q);
   assign taken = ld_valid & ld_ready;
   assign sws_taken = taken && (sel == CSF_SEL_SWS);
   assign gc_taken = taken && (sel == CSF_SEL_GC);
   // A period that finds its frame unsent is counted, not repeated
   assign sws_ovr = sws_fire & sws_pend_q & ~sws_taken;
   assign gc_ovr = gc_fire & gc_pend_q & ~gc_taken;

   // Set wins over the clear by a load in the same cycle
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sws_pend_q <= 1'b0;
         gc_pend_q <= 1'b0;
      end else if (!active) begin
         sws_pend_q <= 1'b0;
         gc_pend_q <= 1'b0;
      end else begin
         sws_pend_q <= sws_fire | (sws_pend_q & ~sws_taken);
         gc_pend_q <= gc_fire | (gc_pend_q & ~gc_taken);
      end
   end

   // Sent counts wrap; software compares successive reads
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sws_sent_q <= 8'h00;
         gc_sent_q <= 8'h00;
      end else begin
         if (sws_taken) begin
            sws_sent_q <= 8'(sws_sent_q + 1'b1);
         end
         if (gc_taken) begin
            gc_sent_q <= 8'(gc_sent_q + 1'b1);
         end
      end
   end

   // Counts cycles in which either period found its frame still waiting (both at once count one); saturates
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ovr_q <= 8'h00;
      end else if ((sws_ovr || gc_ovr) && ovr_q != 8'hFF) begin
         ovr_q <= 8'(ovr_q + 1'b1);
      end else if (ovr_clr && !(sws_ovr || gc_ovr)) begin
         ovr_q <= 8'h00;
      end
   end

   // ------------------------------------------------------------
   // Frame assembly
   // ------------------------------------------------------------
   // Bit 1 is the least significant bit of a byte
   assign sws_byte1 = {2'b11, brk_code(util_q), brk_code(gen_q)};
   // Bits 1-3 and 6-8 belong to parameters not implemented here
   assign gc_byte1 = {3'b111, nr_q, 3'b111};

   always_comb begin
      frame.dlc = `CSF_DLC;
      // Byte 1 in the top byte so it leaves first
      frame.data = {8'h00, {7{`CSF_FILL_BYTE}}};
      if (sel == CSF_SEL_GC) begin
         frame.can_id = can_ident(`CSF_GC_PS, sa_q);
         frame.data[63:56] = gc_byte1;
      end else begin
         frame.can_id = can_ident(`CSF_SWS_PS, sa_q);
         frame.data[63:56] = sws_byte1;
      end
   end

   // ------------------------------------------------------------
   // Output buffer
   // ------------------------------------------------------------
   // Two entries so a controller stall never tears a frame
   // A full buffer holds the load back; the pending flag keeps the request
   csf_buf #(
      .WIDTH($bits(csf_frame_t)),
      .DEPTH(2)
   ) u_buf (
      .mclk(mclk),
      .rst_n(rst_n),
      .in_valid(ld_valid),
      .in_ready(ld_ready),
      .in_data(frame),
      .out_valid(frm_valid),
      .out_ready(frm_ready),
      .out_data(frm_data)
   );

endmodule // csf_framer

`default_nettype wire

// ===== logic/csf_pkg.sv
package csf_pkg;

   // ------------------------------------------------------------
   // Frame carrier
   // ------------------------------------------------------------
   typedef struct packed {
      logic [28:0] can_id;
      logic [3:0] dlc;
      logic [63:0] data;
   } csf_frame_t;

   typedef enum logic {
      CSF_SEL_SWS,
      CSF_SEL_GC
   } csf_sel_t;

endpackage

// ===== verif/csf_chk.sv
`timescale 1ns/100ps
`default_nettype none

module csf_chk (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Wishbone
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // Frame stream
   input wire logic frm_valid,
   input wire logic frm_ready,
   input wire csf_pkg::csf_frame_t frm_data
);
   import csf_pkg::*;
   logic [7:0] ps;
   logic [2:0] gen;
   logic [2:0] util;
   assign ps = frm_data.can_id[15:8];
   assign gen = frm_data.data[58:56];
   assign util = frm_data.data[61:59];

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   ack_delay_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing one cycle after request");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   fixed_prio_a: assert property (frm_valid |-> frm_data.can_id[28:26] == 3'h3)
      else $error("priority not 3");
   group_num_a: assert property (frm_valid |-> frm_data.can_id[25:16] == 10'h0FD && (ps == 8'h91 || ps == 8'h93))
      else $error("bad group number");
   frame_len_a: assert property (frm_valid |-> frm_data.dlc == 4'h8)
      else $error("length not eight");
   fill_ones_a: assert property (frm_valid |-> (&frm_data.data[55:0]) && frm_data.data[63:62] == 2'b11)
      else $error("unused bits not ones");
   gc_unused_a: assert property (frm_valid && ps == 8'h93 |-> gen == 3'h7 && frm_data.data[61])
      else $error("control low bits not ones");
   brk_code_a: assert property (frm_valid && ps == 8'h91 |-> !(gen inside {[3:5]}) && !(util inside {[3:5]}))
      else $error("reserved breaker code sent");
   stall_hold_a: assert property (frm_valid && !frm_ready |=> frm_valid && $stable(frm_data))
      else $error("frame lost under stall");
endmodule // csf_chk

bind csf_framer csf_chk u_chk (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .frm_valid(frm_valid), .frm_ready(frm_ready), .frm_data(frm_data));

`default_nettype wire

// ===== verif/csf_sink.sv
`timescale 1ns/100ps
`default_nettype none

module csf_sink (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Frame stream
   input wire logic frm_valid,
   output logic frm_ready,
   input wire csf_pkg::csf_frame_t frm_data,
   // Bench control and record
   input wire logic stall,
   output int n_sws,
   output int n_gc,
   output csf_pkg::csf_frame_t last_sws,
   output csf_pkg::csf_frame_t last_gc
);
   import csf_pkg::*;
   // Level ready; a stall may last any number of cycles
   assign frm_ready = !stall;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         n_sws <= 0;
         n_gc <= 0;
      end else if (frm_valid && frm_ready) begin
         if (frm_data.can_id[15:8] == 8'h91) begin
            n_sws <= n_sws + 1;
            last_sws <= frm_data;
         end else begin
            n_gc <= n_gc + 1;
            last_gc <= frm_data;
         end
      end
   end
endmodule // csf_sink

`default_nettype wire

// ===== verif/tb_csf_framer.sv
`timescale 1ns/100ps
`default_nettype none

module tb_csf_framer;
   import csf_pkg::*;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic wb_cyc = 1'b0;
   logic wb_stb = 1'b0;
   logic wb_we = 1'b0;
   logic [7:0] wb_adr = 8'h00;
   logic [31:0] wb_dat = 32'h0000_0000;
   logic [3:0] wb_sel = 4'h0;
   logic [3:0] sel_v = 4'hF;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic frm_valid;
   logic frm_ready;
   logic stall = 1'b0;
   csf_frame_t frm_data;
   csf_frame_t last_sws;
   csf_frame_t last_gc;
   int n_sws;
   int n_gc;
   int errors = 0;
   int total_checks = 0;
   logic [31:0] rd;

   always #5 mclk = ~mclk;

   // Small tick: 10 clocks, switching every 50, control every 20
   csf_framer #(.TICK_CYC(10), .SWS_TICKS(5), .GC_TICKS(2)) u_dut (.mclk(mclk), .rst_n(rst_n),
      .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
      .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .frm_valid(frm_valid),
      .frm_ready(frm_ready), .frm_data(frm_data));
   csf_sink u_sink (.mclk(mclk), .rst_n(rst_n), .frm_valid(frm_valid), .frm_ready(frm_ready),
      .frm_data(frm_data), .stall(stall), .n_sws(n_sws), .n_gc(n_gc), .last_sws(last_sws), .last_gc(last_gc));

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic check(input string name, input logic [96:0] seen, input logic [96:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Request held until the edge that samples ack high
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= a;
      wb_sel <= sel_v;
      wb_dat <= d;
      do begin
         @(posedge mclk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 100);
      if (n >= 100) begin
         errors++;
      end
      rd = wb_dat_o;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_sel <= 4'h0;
   endtask

   function automatic csf_frame_t frame(input logic [7:0] ps, input logic [7:0] b1, input logic [7:0] sa);
      return {3'h3, 1'b0, 1'b0, 8'hFD, ps, sa, 4'h8, b1, 56'hFF_FFFF_FFFF_FFFF};
   endfunction

   function automatic logic [2:0] brk(input logic [2:0] c);
      return (c >= 3'h3 && c <= 3'h5) ? 3'h6 : c;
   endfunction

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_regs();
      logic [7:0] adr [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
      logic [31:0] exp [5] = '{32'h0000_FE00, 32'h0000_003F, 32'h0000_0003, 32'h0000_0000, 32'h0000_0000};
      wb(1'b1, 8'h10, 32'hFFFF_FFFF);
      for (int i = 0; i < 5; i++) begin
         wb(1'b0, adr[i], 32'h0000_0000);
         check("reg reset", rd, exp[i]);
      end
      // Only byte 0 enabled: the source address byte must not move
      sel_v = 4'h1;
      wb(1'b1, 8'h00, 32'h0000_1100);
      sel_v = 4'hF;
      wb(1'b0, 8'h00, 32'h0000_0000);
      check("byte enables", rd, 32'h0000_FE00);
   endtask

   task automatic t_gate();
      wb(1'b1, 8'h00, 32'h0000_4201);
      repeat (120) @(posedge mclk);
      wb(1'b1, 8'h00, 32'h0000_4202);
      repeat (120) @(posedge mclk);
      check("frames while gated", n_sws + n_gc, 0);
   endtask

   task automatic t_rate();
      wb(1'b1, 8'h04, 32'h0000_0011);
      wb(1'b1, 8'h08, 32'h0000_0001);
      wb(1'b1, 8'h00, 32'h0000_4203);
      repeat (210) @(posedge mclk);
      wb(1'b1, 8'h00, 32'h0000_4200);
      repeat (20) @(posedge mclk);
      check("control count", n_gc, 10);
      check("switching count", n_sws, 4);
      check("switching frame", last_sws, frame(8'h91, 8'hD1, 8'h42));
      check("control frame", last_gc, frame(8'h93, 8'hEF, 8'h42));
   endtask

   task automatic t_codes();
      int base;
      int n;
      wb(1'b1, 8'h00, 32'h0000_5A03);
      for (int i = 0; i < 8; i++) begin
         wb(1'b1, 8'h04, {26'h0, 3'(7 - i), 3'(i)});
         wb(1'b1, 8'h08, {30'h0, 2'(i)});
         base = n_sws;
         n = 0;
         while (n_sws < base + 2 && n < 200) begin
            @(posedge mclk);
            n++;
         end
         check("breaker codes", last_sws, frame(8'h91, {2'b11, brk(3'(7 - i)), brk(3'(i))}, 8'h5A));
         check("not ready code", last_gc, frame(8'h93, {3'b111, 2'(i), 3'h7}, 8'h5A));
      end
   endtask

   task automatic t_stall();
      stall <= 1'b1;
      repeat (150) @(posedge mclk);
      wb(1'b0, 8'h0C, 32'h0000_0000);
      check("valid while stalled", rd[2], 1'b1);
      check("overrun counted", |rd[31:24], 1'b1);
      stall <= 1'b0;
      repeat (30) @(posedge mclk);
      wb(1'b1, 8'h00, 32'h0000_5A00);
      repeat (10) @(posedge mclk);
      check("drained", frm_valid, 1'b0);
      check("frame after stall", last_gc, frame(8'h93, 8'hFF, 8'h5A));
      wb(1'b1, 8'h0C, 32'h0000_0000);
      wb(1'b0, 8'h0C, 32'h0000_0000);
      check("overrun cleared", rd[31:24], 8'h00);
   endtask

   // ------------------------------------------------------------
   // Run control
   // ------------------------------------------------------------
   task automatic results();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   initial begin
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      t_regs();
      t_gate();
      t_rate();
      t_codes();
      t_stall();
      results();
   end

   // Whole run needs about 1500 cycles
   initial begin
      repeat (20000) @(posedge mclk);
      errors++;
      results();
   end
endmodule // tb_csf_framer

`default_nettype wire
